// ---- gpv_pkg.sv ----
// Constants, register map and types for the eight-bit I/O port group with interrupt vectors.
// Function
// - Vector reads zero with nothing pending.
// - Vector is twice pin plus two, pin0 first.
// - Vector is 16-bit read-only, only bits 4..1 nonzero.
// - Every port has its own identical vector.
// - Input register shows each pin's level.
// - Output pin drives its output register bit.
// - Output bit picks pull-up or pull-down.
// - Direction one means output; resets to zero.
// - Resistor enable acts only on inputs.
// - Two select bits choose gpio or module function.
// - Select bits map per pin; reset zero.
// - Complement write flips both select bits; reads zero.
// - Edge select zero rising, one falling sets flag.
// - Interrupt enable gates each pin; resets zero.
// - Flag holds while pending; software reads/writes it.
package gpv_pkg;
	// Byte offsets of the per-port registers inside one port window.
	localparam logic [5:0] OFF_INPUT = 6'h00;
	localparam logic [5:0] OFF_OUTPUT = 6'h04;
	localparam logic [5:0] OFF_DIR = 6'h08;
	localparam logic [5:0] OFF_PULL_EN = 6'h0c;
	localparam logic [5:0] OFF_SEL_LOW = 6'h10;
	localparam logic [5:0] OFF_SEL_HIGH = 6'h14;
	localparam logic [5:0] OFF_SEL_TOGGLE = 6'h18;
	localparam logic [5:0] OFF_EDGE_POL = 6'h1c;
	localparam logic [5:0] OFF_IRQ_EN = 6'h20;
	localparam logic [5:0] OFF_IRQ_FLAG = 6'h24;
	localparam logic [5:0] OFF_VECTOR = 6'h28;
	// Each port owns a 64-byte window; the address bits above it pick the port.
	localparam int PORT_SHIFT = 6;
	localparam int ADR_W = 8;
	// Reset values.
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] VEC_NONE = 16'h0000;
	// Function select codes, high select bit first.
	localparam logic [1:0] FSEL_GPIO = 2'b00;
	localparam logic [1:0] FSEL_PRIMARY = 2'b01;
	localparam logic [1:0] FSEL_SECONDARY = 2'b10;
	localparam logic [1:0] FSEL_TERTIARY = 2'b11;
	// Bus slave states.
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} gpv_bus_state_t;
endpackage

// ---- gpv_port.sv ----
// Group of eight-bit I/O ports with pin interrupts, prioritised vectors and a Wishbone register slave.
`timescale 1ns/1ps
module gpv_port #(
	parameter int NUM_PORTS = 3
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Wishbone classic slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [gpv_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Pads, eight per port, port 0 in the low byte.
	input wire logic [NUM_PORTS*8-1:0] pad_in,
	output logic [NUM_PORTS*8-1:0] pad_out,
	output logic [NUM_PORTS*8-1:0] pad_oe,
	output logic [NUM_PORTS*8-1:0] pad_pull_en,
	output logic [NUM_PORTS*8-1:0] pad_pull_up,
	// Peripheral module functions that may own a pin.
	input wire logic [NUM_PORTS*8-1:0] mod1_out,
	input wire logic [NUM_PORTS*8-1:0] mod1_oe,
	input wire logic [NUM_PORTS*8-1:0] mod2_out,
	input wire logic [NUM_PORTS*8-1:0] mod2_oe,
	input wire logic [NUM_PORTS*8-1:0] mod3_out,
	input wire logic [NUM_PORTS*8-1:0] mod3_oe,
	// Per-port interrupt requests.
	output logic [NUM_PORTS-1:0] port_irq
);
	import gpv_pkg::*;

	gpv_bus_state_t state_reg;
	gpv_bus_state_t state_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [NUM_PORTS-1:0][7:0] in_reg;
	logic in_valid_reg;
	logic [NUM_PORTS-1:0][7:0] out_reg;
	logic [NUM_PORTS-1:0][7:0] dir_reg;
	logic [NUM_PORTS-1:0][7:0] ren_reg;
	logic [NUM_PORTS-1:0][7:0] sel0_reg;
	logic [NUM_PORTS-1:0][7:0] sel1_reg;
	logic [NUM_PORTS-1:0][7:0] ies_reg;
	logic [NUM_PORTS-1:0][7:0] ie_reg;
	logic [NUM_PORTS-1:0][7:0] ifg_reg;
	logic [NUM_PORTS-1:0][7:0] ifg_next;
	logic [NUM_PORTS-1:0][7:0] edge_set;
	logic [NUM_PORTS-1:0][7:0] pending;
	logic [NUM_PORTS-1:0][15:0] vec;
	logic wr_ok;
	logic [7:0] wbyte;

	// Highest-priority pending pin, pin 0 first, coded as twice the pin plus two.
	function automatic logic [15:0] gpv_vector(input logic [7:0] pend);
		logic [15:0] v;
		v = VEC_NONE;
		for (int i = 7; i >= 0; i--) begin
			if (pend[i]) begin
				v = 16'(2 * i + 2);
			end
		end
		return v;
	endfunction

	// True when the bus address selects register off of port p.
	function automatic logic gpv_hit(input logic [ADR_W-1:0] adr, input int p, input logic [5:0] off);
		logic [ADR_W-1:0] base;
		base = ADR_W'(p << PORT_SHIFT);
		return (adr[ADR_W-1:PORT_SHIFT] == base[ADR_W-1:PORT_SHIFT]) && (adr[PORT_SHIFT-1:0] == off);
	endfunction

	// A write lands at the edge where the master sees ack, so it happens exactly once.
	assign wr_ok = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && (state_reg == BUS_ACK);
	assign wbyte = wb_dat_i[7:0];
	assign wb_ack_o = (state_reg == BUS_ACK);
	assign wb_dat_o = rdata_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			BUS_IDLE: begin
				if (wb_cyc_i && wb_stb_i) begin
					state_next = BUS_ACK;
				end
			end
			BUS_ACK: begin
				state_next = BUS_IDLE;
			end
			default: begin
				state_next = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= BUS_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Read mux; unmapped addresses and the complement register read as zero.
	always_comb begin
		rdata_next = 32'h0000_0000;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (gpv_hit(wb_adr_i, p, OFF_INPUT)) begin
				rdata_next[7:0] = in_reg[p];
			end
			if (gpv_hit(wb_adr_i, p, OFF_OUTPUT)) begin
				rdata_next[7:0] = out_reg[p];
			end
			if (gpv_hit(wb_adr_i, p, OFF_DIR)) begin
				rdata_next[7:0] = dir_reg[p];
			end
			if (gpv_hit(wb_adr_i, p, OFF_PULL_EN)) begin
				rdata_next[7:0] = ren_reg[p];
			end
			if (gpv_hit(wb_adr_i, p, OFF_SEL_LOW)) begin
				rdata_next[7:0] = sel0_reg[p];
			end
			if (gpv_hit(wb_adr_i, p, OFF_SEL_HIGH)) begin
				rdata_next[7:0] = sel1_reg[p];
			end
			if (gpv_hit(wb_adr_i, p, OFF_EDGE_POL)) begin
				rdata_next[7:0] = ies_reg[p];
			end
			if (gpv_hit(wb_adr_i, p, OFF_IRQ_EN)) begin
				rdata_next[7:0] = ie_reg[p];
			end
			if (gpv_hit(wb_adr_i, p, OFF_IRQ_FLAG)) begin
				rdata_next[7:0] = ifg_reg[p];
			end
			if (gpv_hit(wb_adr_i, p, OFF_VECTOR)) begin
				rdata_next[15:0] = vec[p];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_reg <= 32'h0000_0000;
		end else if (state_reg == BUS_IDLE && wb_cyc_i && wb_stb_i) begin
			rdata_reg <= rdata_next;
		end
	end

	// Input sampling; edges are masked for the first cycle so reset does not fake a transition.
	always_ff @(posedge mclk) begin
		if (rst) begin
			in_reg <= '0;
			in_valid_reg <= 1'b0;
		end else begin
			in_valid_reg <= 1'b1;
			for (int p = 0; p < NUM_PORTS; p++) begin
				in_reg[p] <= pad_in[p*8 +: 8];
			end
		end
	end

	// Plain configuration registers. Output and edge select get a zero reset only to keep simulation clean.
	always_ff @(posedge mclk) begin
		if (rst) begin
			out_reg <= '0;
			dir_reg <= '0;
			ren_reg <= '0;
			ies_reg <= '0;
			ie_reg <= '0;
		end else if (wr_ok) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (gpv_hit(wb_adr_i, p, OFF_OUTPUT)) begin
					out_reg[p] <= wbyte;
				end
				if (gpv_hit(wb_adr_i, p, OFF_DIR)) begin
					dir_reg[p] <= wbyte;
				end
				if (gpv_hit(wb_adr_i, p, OFF_PULL_EN)) begin
					ren_reg[p] <= wbyte;
				end
				if (gpv_hit(wb_adr_i, p, OFF_EDGE_POL)) begin
					ies_reg[p] <= wbyte;
				end
				if (gpv_hit(wb_adr_i, p, OFF_IRQ_EN)) begin
					ie_reg[p] <= wbyte;
				end
			end
		end
	end

	// Function select pair. The complement write flips both halves in one edge, so no
	// intermediate function is ever seen on the pin.
	always_ff @(posedge mclk) begin
		if (rst) begin
			sel0_reg <= '0;
			sel1_reg <= '0;
		end else if (wr_ok) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (gpv_hit(wb_adr_i, p, OFF_SEL_LOW)) begin
					sel0_reg[p] <= wbyte;
				end
				if (gpv_hit(wb_adr_i, p, OFF_SEL_HIGH)) begin
					sel1_reg[p] <= wbyte;
				end
				if (gpv_hit(wb_adr_i, p, OFF_SEL_TOGGLE)) begin
					sel0_reg[p] <= sel0_reg[p] ^ wbyte;
					sel1_reg[p] <= sel1_reg[p] ^ wbyte;
				end
			end
		end
	end

	// Edge detection and flag update; a detected edge wins over a software clear in the same cycle.
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			edge_set[p] = '0;
			if (in_valid_reg) begin
				edge_set[p] = (pad_in[p*8 +: 8] & ~in_reg[p] & ~ies_reg[p])
					| (~pad_in[p*8 +: 8] & in_reg[p] & ies_reg[p]);
			end
			ifg_next[p] = ifg_reg[p];
			if (wr_ok && gpv_hit(wb_adr_i, p, OFF_IRQ_FLAG)) begin
				ifg_next[p] = wbyte;
			end
			ifg_next[p] = ifg_next[p] | edge_set[p];
			pending[p] = ifg_reg[p] & ie_reg[p];
			vec[p] = gpv_vector(pending[p]);
			port_irq[p] = |pending[p];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ifg_reg <= '0;
		end else begin
			ifg_reg <= ifg_next;
		end
	end

	// Pin multiplexer. Module functions take both drive and enable; pulls are a gpio-input feature only.
	always_comb begin
		pad_out = '0;
		pad_oe = '0;
		pad_pull_en = '0;
		pad_pull_up = '0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			for (int i = 0; i < 8; i++) begin
				case ({sel1_reg[p][i], sel0_reg[p][i]})
					FSEL_GPIO: begin
						pad_oe[p*8+i] = dir_reg[p][i];
						pad_out[p*8+i] = out_reg[p][i];
						pad_pull_en[p*8+i] = ~dir_reg[p][i] & ren_reg[p][i];
						pad_pull_up[p*8+i] = out_reg[p][i];
					end
					FSEL_PRIMARY: begin
						pad_oe[p*8+i] = mod1_oe[p*8+i];
						pad_out[p*8+i] = mod1_out[p*8+i];
					end
					FSEL_SECONDARY: begin
						pad_oe[p*8+i] = mod2_oe[p*8+i];
						pad_out[p*8+i] = mod2_out[p*8+i];
					end
					FSEL_TERTIARY: begin
						pad_oe[p*8+i] = mod3_oe[p*8+i];
						pad_out[p*8+i] = mod3_out[p*8+i];
					end
					default: begin
						pad_oe[p*8+i] = 1'b0;
					end
				endcase
			end
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	for (genvar g = 0; g < NUM_PORTS; g++) begin : g_chk
		a_vector_idle: assert property ((ifg_reg[g] & ie_reg[g]) == 8'h00 |-> vec[g] == 16'h0000)
			else $error("vector not zero with nothing pending");
		a_vector_first: assert property (ifg_reg[g][0] && ie_reg[g][0] |-> vec[g] == 16'h0002)
			else $error("pin 0 not reported first");
		a_vector_last: assert property ((ifg_reg[g] & ie_reg[g]) == 8'h80 |-> vec[g] == 16'h0010)
			else $error("pin 7 vector wrong");
		a_vector_bits: assert property (vec[g][15:5] == 11'h000 && vec[g][0] == 1'b0)
			else $error("vector has bits outside 4..1");
		a_irq_level: assert property (port_irq[g] == |(ifg_reg[g] & ie_reg[g]))
			else $error("port request does not follow flags and enables");
		a_edge_flag: assert property (edge_set[g] != 8'h00 |=> (ifg_reg[g] & $past(edge_set[g])) == $past(edge_set[g]))
			else $error("edge did not set its flag");
		a_flag_hold: assert property (!(wr_ok && gpv_hit(wb_adr_i, g, OFF_IRQ_FLAG))
			|=> (ifg_reg[g] & $past(ifg_reg[g])) == $past(ifg_reg[g]))
			else $error("flag dropped without a software write");
		a_selc_flip: assert property (wr_ok && gpv_hit(wb_adr_i, g, OFF_SEL_TOGGLE)
			|=> sel0_reg[g] == ($past(sel0_reg[g]) ^ $past(wbyte)) && sel1_reg[g] == ($past(sel1_reg[g]) ^ $past(wbyte)))
			else $error("complement write did not flip both selects");
		a_out_drive: assert property (sel0_reg[g] == 8'h00 && sel1_reg[g] == 8'h00
			|-> pad_oe[g*8 +: 8] == dir_reg[g] && (pad_out[g*8 +: 8] & dir_reg[g]) == (out_reg[g] & dir_reg[g]))
			else $error("gpio output drive wrong");
		a_pull_select: assert property (sel0_reg[g] == 8'h00 && sel1_reg[g] == 8'h00
			|-> pad_pull_en[g*8 +: 8] == (ren_reg[g] & ~dir_reg[g])
			&& (pad_pull_up[g*8 +: 8] & pad_pull_en[g*8 +: 8]) == (out_reg[g] & pad_pull_en[g*8 +: 8]))
			else $error("pull resistor control wrong");
		a_pull_module: assert property ((pad_pull_en[g*8 +: 8] & (sel0_reg[g] | sel1_reg[g])) == 8'h00)
			else $error("pull enabled on a module function pin");
		a_irq_masked: assert property ((ifg_reg[g] & ie_reg[g]) == 8'h00 |-> !port_irq[g])
			else $error("port request without an enabled flag");
		a_edge_masked: assert property (!in_valid_reg |-> edge_set[g] == 8'h00)
			else $error("edge seen before the first valid sample");
		a_in_sample: assert property (1'b1 |=> in_reg[g] == $past(pad_in[g*8 +: 8]))
			else $error("input register does not follow the pins");
		a_rise_sets: assert property (in_valid_reg
			|=> (~ifg_reg[g] & $past(pad_in[g*8 +: 8]) & ~$past(in_reg[g]) & ~$past(ies_reg[g])) == 8'h00)
			else $error("rising edge did not set its flag");
		a_fall_sets: assert property (in_valid_reg
			|=> (~ifg_reg[g] & ~$past(pad_in[g*8 +: 8]) & $past(in_reg[g]) & $past(ies_reg[g])) == 8'h00)
			else $error("falling edge did not set its flag");
		a_no_false_flag: assert property (!(wr_ok && gpv_hit(wb_adr_i, g, OFF_IRQ_FLAG))
			|=> (ifg_reg[g] & ~$past(ifg_reg[g]) & ~$past(edge_set[g])) == 8'h00)
			else $error("flag set without an edge");

		// Module functions own both drive and enable of every pin that selects them.
		a_mod1_route: assert property ((((pad_out[g*8 +: 8] ^ mod1_out[g*8 +: 8])
			| (pad_oe[g*8 +: 8] ^ mod1_oe[g*8 +: 8])) & sel0_reg[g] & ~sel1_reg[g]) == 8'h00)
			else $error("primary function not routed");
		a_mod2_route: assert property ((((pad_out[g*8 +: 8] ^ mod2_out[g*8 +: 8])
			| (pad_oe[g*8 +: 8] ^ mod2_oe[g*8 +: 8])) & ~sel0_reg[g] & sel1_reg[g]) == 8'h00)
			else $error("secondary function not routed");
		a_mod3_route: assert property ((((pad_out[g*8 +: 8] ^ mod3_out[g*8 +: 8])
			| (pad_oe[g*8 +: 8] ^ mod3_oe[g*8 +: 8])) & sel0_reg[g] & sel1_reg[g]) == 8'h00)
			else $error("tertiary function not routed");

		// Writes land at the acking edge and take the low data byte.
		a_out_write: assert property (wr_ok && gpv_hit(wb_adr_i, g, OFF_OUTPUT)
			|=> out_reg[g] == $past(wbyte))
			else $error("output write lost");
		a_dir_write: assert property (wr_ok && gpv_hit(wb_adr_i, g, OFF_DIR)
			|=> dir_reg[g] == $past(wbyte))
			else $error("direction write lost");
		a_pull_write: assert property (wr_ok && gpv_hit(wb_adr_i, g, OFF_PULL_EN)
			|=> ren_reg[g] == $past(wbyte))
			else $error("resistor enable write lost");
		a_pol_write: assert property (wr_ok && gpv_hit(wb_adr_i, g, OFF_EDGE_POL)
			|=> ies_reg[g] == $past(wbyte))
			else $error("edge select write lost");
		a_ie_write: assert property (wr_ok && gpv_hit(wb_adr_i, g, OFF_IRQ_EN)
			|=> ie_reg[g] == $past(wbyte))
			else $error("interrupt enable write lost");
		a_sel_low_write: assert property (wr_ok && gpv_hit(wb_adr_i, g, OFF_SEL_LOW)
			|=> sel0_reg[g] == $past(wbyte))
			else $error("low select write lost");
		a_sel_high_write: assert property (wr_ok && gpv_hit(wb_adr_i, g, OFF_SEL_HIGH)
			|=> sel1_reg[g] == $past(wbyte))
			else $error("high select write lost");
		a_flag_write: assert property (wr_ok && gpv_hit(wb_adr_i, g, OFF_IRQ_FLAG)
			|=> ifg_reg[g] == ($past(wbyte) | $past(edge_set[g])))
			else $error("flag write lost or edge dropped");

		// Read data is captured when the request is taken and stands while ack is high.
		a_toggle_read: assert property (state_reg == BUS_IDLE && wb_cyc_i && wb_stb_i && !wb_we_i
			&& gpv_hit(wb_adr_i, g, OFF_SEL_TOGGLE) |=> wb_dat_o == 32'h0000_0000)
			else $error("complement register read not zero");
		a_vector_read: assert property (state_reg == BUS_IDLE && wb_cyc_i && wb_stb_i && !wb_we_i
			&& gpv_hit(wb_adr_i, g, OFF_VECTOR) |=> wb_dat_o == {16'h0000, $past(vec[g])})
			else $error("vector read wrong");
	end

	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held for more than one cycle");
	a_ack_latency: assert property (state_reg == BUS_IDLE && wb_cyc_i && wb_stb_i |=> wb_ack_o)
		else $error("request not acknowledged in the next cycle");
	a_dir_reset: assert property ($past(rst) && !rst |-> dir_reg == '0 && ie_reg == '0)
		else $error("direction or enable not cleared by reset");
	a_sel_reset: assert property ($past(rst) && !rst |-> sel0_reg == '0 && sel1_reg == '0 && port_irq == '0)
		else $error("selects or request not cleared by reset");
endmodule

// ---- gpv_pin_model.sv ----
// Behavioural model of the pads, an outside source and the pull load seen by the port.
`timescale 1ns/1ps
module gpv_pin_model #(
	parameter int W = 24
) (
	// Clock.
	input wire logic mclk,
	// Port side of the pads.
	input wire logic [W-1:0] pad_out,
	input wire logic [W-1:0] pad_oe,
	input wire logic [W-1:0] pad_pull_en,
	input wire logic [W-1:0] pad_pull_up,
	// Outside source driven by the bench.
	input wire logic [W-1:0] ext_en,
	input wire logic [W-1:0] ext_val,
	// Resolved pin level.
	output logic [W-1:0] pad_in
);
	logic [W-1:0] float_reg = '0;
	// An undriven pin has no settled level, so it shows the inverse of its last level each cycle.
	always_ff @(posedge mclk) begin
		float_reg <= ~pad_in;
	end
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (pad_oe[i]) begin
				pad_in[i] = pad_out[i];
			end else if (ext_en[i]) begin
				pad_in[i] = ext_val[i];
			end else if (pad_pull_en[i]) begin
				pad_in[i] = pad_pull_up[i];
			end else begin
				pad_in[i] = float_reg[i];
			end
		end
	end
endmodule

// ---- gpv_port_tb_top.sv ----
// Self-checking testbench for the port group: registers, pads, select complement and pin interrupts.
`timescale 1ns/1ps
module gpv_port_tb_top;
	import gpv_pkg::*;
	logic mclk, rst, wb_cyc, wb_stb, wb_we, wb_ack;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_dat_w, wb_dat_r, rd;
	logic [23:0] pad_in, pad_out, pad_oe, pad_pull_en, pad_pull_up, ext_en, ext_val;
	logic [23:0] mod1_out, mod1_oe, mod2_out, mod2_oe, mod3_out, mod3_oe;
	logic [2:0] port_irq;
	int error_cnt = 0;
	int check_count = 0;
	int cyc_cnt = 0;

	gpv_port #(.NUM_PORTS(3)) gpv_port_i (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
		.wb_ack_o(wb_ack), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
		.pad_pull_up(pad_pull_up), .mod1_out(mod1_out), .mod1_oe(mod1_oe), .mod2_out(mod2_out),
		.mod2_oe(mod2_oe), .mod3_out(mod3_out), .mod3_oe(mod3_oe), .port_irq(port_irq));
	gpv_pin_model #(.W(24)) gpv_pin_model_i (.mclk(mclk), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pull_en(pad_pull_en), .pad_pull_up(pad_pull_up), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// A hang in any wait ends the run here rather than stalling the simulator.
	always @(posedge mclk) begin
		cyc_cnt++;
		if (cyc_cnt == 3000) begin
			error_cnt++;
			give_verdict();
		end
	end

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_dat_w <= d;
		wb_sel <= 4'hf;
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack !== 1'b1);
		rd = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		// The slave takes the request at the first edge and answers at the second.
		chk_reg(n, 32'h2);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		wb_xfer(1'b0, a, 32'h0);
		chk_reg(rd, exp);
	endtask

	task automatic t_reset;
		logic [5:0] offs [7] = '{OFF_DIR, OFF_PULL_EN, OFF_SEL_LOW, OFF_SEL_HIGH, OFF_IRQ_EN, OFF_IRQ_FLAG, OFF_VECTOR};
		for (int p = 0; p < 3; p++) begin
			foreach (offs[k]) rd_chk({p[1:0], offs[k]}, 32'h0);
		end
		rd_chk({2'h0, OFF_SEL_TOGGLE}, 32'h0);
		rd_chk(8'h2c, 32'h0);
		rd_chk(8'hc0, 32'h0);
		chk_pin({21'h0, port_irq}, 24'h0);
		$display("reset test done");
	endtask

	task automatic t_pull;
		wb_xfer(1'b1, {2'h0, OFF_OUTPUT}, 32'h05);
		wb_xfer(1'b1, {2'h0, OFF_PULL_EN}, 32'h0f);
		@(posedge mclk);
		chk_pin(pad_pull_en, 24'h00000f);
		chk_pin(pad_pull_up & 24'h00000f, 24'h000005);
		wb_xfer(1'b1, {2'h0, OFF_DIR}, 32'h01);
		@(posedge mclk);
		chk_pin(pad_pull_en, 24'h00000e);
		chk_pin(pad_oe, 24'h000001);
		chk_pin(pad_out & 24'h000001, 24'h000001);
		$display("pull test done");
	endtask

	task automatic t_drive;
		ext_en <= 24'hffff00;
		wb_xfer(1'b1, {2'h0, OFF_DIR}, 32'hff);
		wb_xfer(1'b1, {2'h0, OFF_OUTPUT}, 32'ha5);
		repeat (3) @(posedge mclk);
		chk_pin(pad_oe, 24'h0000ff);
		chk_pin(pad_out & 24'h0000ff, 24'h0000a5);
		chk_pin(pad_pull_en, 24'h0);
		rd_chk({2'h0, OFF_INPUT}, 32'ha5);
		rd_chk({2'h0, OFF_OUTPUT}, 32'ha5);
		$display("drive test done");
	endtask

	// Pin i takes output and enable from the source picked by its two select bits, high bit first.
	task automatic chk_mux(input logic [7:0] lo, input logic [7:0] hi);
		logic [7:0] mo [4];
		logic [7:0] me [4];
		logic [7:0] eo, ee;
		mo = '{8'ha5, mod1_out[7:0], mod2_out[7:0], mod3_out[7:0]};
		me = '{8'hff, mod1_oe[7:0], mod2_oe[7:0], mod3_oe[7:0]};
		for (int i = 0; i < 8; i++) begin
			eo[i] = mo[{hi[i], lo[i]}][i];
			ee[i] = me[{hi[i], lo[i]}][i];
		end
		chk_pin({16'h0, pad_out[7:0]}, {16'h0, eo});
		chk_pin({16'h0, pad_oe[7:0]}, {16'h0, ee});
	endtask

	task automatic t_sel;
		mod1_out <= 24'h00000f;
		mod1_oe <= 24'h0000ff;
		mod2_out <= 24'h000033;
		mod2_oe <= 24'h00000f;
		mod3_out <= 24'h000055;
		mod3_oe <= 24'h0000f0;
		wb_xfer(1'b1, {2'h0, OFF_SEL_LOW}, 32'hcc);
		wb_xfer(1'b1, {2'h0, OFF_SEL_HIGH}, 32'hf0);
		@(posedge mclk);
		chk_mux(8'hcc, 8'hf0);
		wb_xfer(1'b1, {2'h0, OFF_SEL_TOGGLE}, 32'h3c);
		@(posedge mclk);
		chk_mux(8'hf0, 8'hcc);
		rd_chk({2'h0, OFF_SEL_LOW}, 32'hf0);
		rd_chk({2'h0, OFF_SEL_HIGH}, 32'hcc);
		rd_chk({2'h0, OFF_SEL_TOGGLE}, 32'h0);
		$display("select test done");
	endtask

	task automatic t_irq;
		ext_val[15:8] <= 8'h02;
		wb_xfer(1'b1, {2'h1, OFF_EDGE_POL}, 32'h12);
		wb_xfer(1'b1, {2'h1, OFF_IRQ_EN}, 32'hff);
		wb_xfer(1'b1, {2'h1, OFF_IRQ_FLAG}, 32'h00);
		ext_val[15:8] <= 8'h18;
		repeat (2) @(posedge mclk);
		rd_chk({2'h1, OFF_IRQ_FLAG}, 32'h0a);
		rd_chk({2'h1, OFF_VECTOR}, 32'h0004);
		chk_pin({21'h0, port_irq}, 24'h2);
		wb_xfer(1'b1, {2'h1, OFF_IRQ_FLAG}, 32'h08);
		rd_chk({2'h1, OFF_VECTOR}, 32'h0008);
		wb_xfer(1'b1, {2'h1, OFF_IRQ_EN}, 32'h00);
		rd_chk({2'h1, OFF_VECTOR}, 32'h0000);
		rd_chk({2'h1, OFF_IRQ_FLAG}, 32'h08);
		chk_pin({21'h0, port_irq}, 24'h0);
		wb_xfer(1'b1, {2'h2, OFF_EDGE_POL}, 32'h00);
		wb_xfer(1'b1, {2'h2, OFF_IRQ_EN}, 32'h80);
		ext_val[23:16] <= 8'h81;
		repeat (2) @(posedge mclk);
		rd_chk({2'h2, OFF_IRQ_FLAG}, 32'h81);
		rd_chk({2'h2, OFF_VECTOR}, 32'h0010);
		chk_pin({21'h0, port_irq}, 24'h4);
		wb_xfer(1'b1, {2'h2, OFF_IRQ_EN}, 32'h81);
		rd_chk({2'h2, OFF_VECTOR}, 32'h0002);
		wb_xfer(1'b1, {2'h2, OFF_IRQ_FLAG}, 32'h00);
		rd_chk({2'h2, OFF_VECTOR}, 32'h0000);
		$display("interrupt test done");
	endtask

	initial begin
		rst = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_sel = 4'h0;
		wb_dat_w = 32'h0;
		ext_en = 24'hffffff;
		ext_val = 24'h0;
		{mod1_out, mod1_oe, mod2_out, mod2_oe, mod3_out, mod3_oe} = '0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_reset();
		t_pull();
		t_drive();
		t_sel();
		t_irq();
		give_verdict();
	end
endmodule
